// [rtl/smh_fault_check.sv]
// Purpose: classify one host access as allowed or faulting
// Assumes: protection inputs already resolved per block by the caller
// Notes:   purely combinational, reserved area is at or above the top
`timescale 1ns/1ps
module smh_fault_check #(
	parameter int AW = 21
) (
	req,
	top_addr,
	rd_fault,
	wr_fault
);
	input  wire smh_pkg::smh_host_req_t req;
	input  wire logic [AW-1:0]          top_addr;
	output      logic                   rd_fault;
	output      logic                   wr_fault;

	logic out_of_range;

	// Address past the main block is reserved core space
	assign out_of_range = (req.addr >= top_addr);
	assign rd_fault = req.valid & ~req.write
		& (req.blk_rd_prot | out_of_range);
	// Writes fault on the read-protect bit as well as the write-protect bit
	assign wr_fault = req.valid & req.write
		& (req.blk_rd_prot | req.blk_wr_prot | out_of_range);
endmodule

// [rtl/smh_host_access_ctrl.sv]
// Purpose: core-side control/status for host shared memory access
// Assumes: classic Wishbone slave on mclk, single-cycle ack
// Notes:   fault verdicts are combinational toward the bridge
`timescale 1ns/1ps
module smh_host_access_ctrl #(
	parameter int          AW         = 21,
	parameter logic [4:0]  FLASH_SIZE = smh_pkg::RST_SIZE_FIELD
) (
	mclk,
	reset,
	power_up_reset,
	force_top_zero,
	development_environment,
	wb_cyc_i,
	wb_stb_i,
	wb_we_i,
	wb_adr_i,
	wb_sel_i,
	wb_dat_i,
	wb_dat_o,
	wb_ack_o,
	host_req,
	host_semaphore_bits,
	host_rsp,
	bridge_write_permit,
	main_block_top_address,
	core_override_reload,
	fault_irq,
	sem_irq,
	irq
);
	input  wire logic                   mclk;
	input  wire logic                   reset;
	input  wire logic                   power_up_reset;
	input  wire logic                   force_top_zero;
	input  wire logic                   development_environment;
	input  wire logic                   wb_cyc_i;
	input  wire logic                   wb_stb_i;
	input  wire logic                   wb_we_i;
	input  wire logic [7:0]             wb_adr_i;
	input  wire logic [3:0]             wb_sel_i;
	input  wire logic [31:0]            wb_dat_i;
	output      logic [31:0]            wb_dat_o;
	output      logic                   wb_ack_o;
	input  wire smh_pkg::smh_host_req_t host_req;
	input  wire logic [3:0]             host_semaphore_bits;
	output      smh_pkg::smh_host_rsp_t host_rsp;
	output      logic                   bridge_write_permit;
	output      logic [AW-1:0]          main_block_top_address;
	output      logic                   core_override_reload;
	output      logic                   fault_irq;
	output      logic                   sem_irq;
	output      logic                   irq;

	// Synchronised straps and environment level
	logic [1:0] force_sync_r;
	logic [1:0] dev_sync_r;
	logic       force_q;
	logic       dev_q;

	// Register state
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic [4:0] size_r;
	logic [4:0] size_nxt;
	logic [2:0] ev_stat_r;
	logic [2:0] ev_stat_nxt;
	logic [2:0] ev_mask_r;
	logic [2:0] ev_mask_nxt;
	logic [20:0] fault_addr_r;
	logic [20:0] fault_addr_nxt;
	logic       ack_r;
	logic       ack_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic       reload_r;
	logic       reload_nxt;
	logic       por_done_r;

	// Decode helpers
	logic       bus_req;
	logic       bus_wr;
	logic       bus_rd;
	logic       rd_fault;
	logic       wr_fault;
	logic       sem_event;
	smh_pkg::smh_resp_t resp_mode;

	// Straps come from pins: two flops before use. No reset here, so the
	// strap is already settled when power-up reset lets go.
	always_ff @(posedge mclk) begin
		force_sync_r <= {force_sync_r[0], force_top_zero};
		dev_sync_r   <= {dev_sync_r[0], development_environment};
	end
	assign force_q = force_sync_r[1];
	assign dev_q   = dev_sync_r[1];

	// Classify the current host access
	smh_fault_check #(
		.AW(AW)
	) u_check (
		.req      (host_req),
		.top_addr (main_block_top_address),
		.rd_fault (rd_fault),
		.wr_fault (wr_fault)
	);

	assign sem_event = host_req.valid & host_req.write & host_req.sem_write;
	assign resp_mode = smh_pkg::smh_resp_t'(ctrl_r[smh_pkg::BIT_RESP_LO +: 2]);

	// Verdict to the bridge; reserved mode behaves as long wait, the safe
	// choice since it never hands data back
	always_comb begin
		host_rsp            = '0;
		host_rsp.fault      = rd_fault | wr_fault;
		host_rsp.drop_write = wr_fault;
		unique case (resp_mode)
			smh_pkg::SMH_RESP_LONG_WAIT: host_rsp.long_wait = rd_fault;
			smh_pkg::SMH_RESP_READ_ZERO: host_rsp.read_zero = rd_fault;
			smh_pkg::SMH_RESP_ERR_SYNC:  host_rsp.err_sync  = rd_fault | wr_fault;
			smh_pkg::SMH_RESP_RESERVED:  host_rsp.long_wait = rd_fault;
		endcase
	end

	// Top address is size in 64 KB units
	assign main_block_top_address =
		AW'({size_r, 16'h0000});

	// Write permit gate toward the bridge
	assign bridge_write_permit = ctrl_r[smh_pkg::BIT_PERMIT];

	// Level interrupts, no extra latching
	assign fault_irq = ctrl_r[smh_pkg::BIT_FAULT_IE]
		& (ctrl_r[smh_pkg::BIT_RD_FAULT] | ctrl_r[smh_pkg::BIT_WR_FAULT]);
	assign sem_irq = ctrl_r[smh_pkg::BIT_SEM_IE]
		& ctrl_r[smh_pkg::BIT_SEM_FLAG];
	assign irq = |(ev_stat_r & ev_mask_r);

	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
	assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
	assign bus_rd  = bus_req & ~wb_we_i;
	assign core_override_reload = reload_r;

	// Next state of all registers except por_done_r and the strap flops, and the bus answer
	always_comb begin
		ctrl_nxt       = ctrl_r;
		size_nxt       = size_r;
		ev_stat_nxt    = ev_stat_r;
		ev_mask_nxt    = ev_mask_r;
		fault_addr_nxt = fault_addr_r;
		ack_nxt        = bus_req;
		rdata_nxt      = rdata_r;
		reload_nxt     = 1'b0;
		if (bus_wr) begin
			unique case (wb_adr_i)
				smh_pkg::ADDR_CTRL_STATUS: begin
					// Flags are write-one-to-clear
					ctrl_nxt[smh_pkg::BIT_RD_FAULT] = ctrl_r[smh_pkg::BIT_RD_FAULT]
						& ~wb_dat_i[smh_pkg::BIT_RD_FAULT];
					ctrl_nxt[smh_pkg::BIT_WR_FAULT] = ctrl_r[smh_pkg::BIT_WR_FAULT]
						& ~wb_dat_i[smh_pkg::BIT_WR_FAULT];
					ctrl_nxt[smh_pkg::BIT_SEM_FLAG] = ctrl_r[smh_pkg::BIT_SEM_FLAG]
						& ~wb_dat_i[smh_pkg::BIT_SEM_FLAG];
					ctrl_nxt[smh_pkg::BIT_FAULT_IE] = wb_dat_i[smh_pkg::BIT_FAULT_IE];
					ctrl_nxt[smh_pkg::BIT_RESP_LO +: 2] =
						wb_dat_i[smh_pkg::BIT_RESP_LO +: 2];
					// Firmware should check flash idle before setting this
					ctrl_nxt[smh_pkg::BIT_PERMIT] = wb_dat_i[smh_pkg::BIT_PERMIT];
					ctrl_nxt[smh_pkg::BIT_SEM_IE] = wb_dat_i[smh_pkg::BIT_SEM_IE];
				end
				smh_pkg::ADDR_TOP_SIZE: begin
					if (dev_q) begin
						size_nxt = wb_dat_i[4:0];
					end
				end
				smh_pkg::ADDR_IRQ_STATUS: begin
					ev_stat_nxt = ev_stat_r & ~wb_dat_i[2:0];
				end
				smh_pkg::ADDR_IRQ_MASK: begin
					ev_mask_nxt = wb_dat_i[2:0];
				end
				default: begin
				end
			endcase
		end
		// Hardware sets win over a same-cycle clear
		if (rd_fault) begin
			ctrl_nxt[smh_pkg::BIT_RD_FAULT] = 1'b1;
			ev_stat_nxt[smh_pkg::EV_RD_FAULT] = 1'b1;
			fault_addr_nxt = host_req.addr;
		end
		if (wr_fault) begin
			ctrl_nxt[smh_pkg::BIT_WR_FAULT] = 1'b1;
			ev_stat_nxt[smh_pkg::EV_WR_FAULT] = 1'b1;
			fault_addr_nxt = host_req.addr;
		end
		if (sem_event) begin
			ctrl_nxt[smh_pkg::BIT_SEM_FLAG] = 1'b1;
			ev_stat_nxt[smh_pkg::EV_SEM] = 1'b1;
		end
		if (size_nxt != size_r) begin
			reload_nxt = 1'b1;
		end
		// Forced strap clears the size after power-up; reload follows too
		if (!por_done_r && force_q
			&& (size_r != smh_pkg::RST_SIZE_FORCED)) begin
			reload_nxt = 1'b1;
		end
		if (bus_rd) begin
			unique case (wb_adr_i)
				smh_pkg::ADDR_CTRL_STATUS: rdata_nxt = {24'h000000, ctrl_r};
				smh_pkg::ADDR_TOP_SIZE:    rdata_nxt = {27'h0000000, size_r};
				smh_pkg::ADDR_IRQ_STATUS:  rdata_nxt = {29'h00000000, ev_stat_r};
				smh_pkg::ADDR_IRQ_MASK:    rdata_nxt = {29'h00000000, ev_mask_r};
				smh_pkg::ADDR_FAULT_INFO:  rdata_nxt = {11'h000, fault_addr_r};
				default:                   rdata_nxt = 32'h00000000;
			endcase
		end
	end

	// Registers reset by the ordinary reset; reload_r is set, the rest cleared
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ctrl_r       <= smh_pkg::RST_CTRL_STATUS;
			ev_stat_r    <= 3'h0;
			ev_mask_r    <= smh_pkg::RST_IRQ_MASK;
			fault_addr_r <= 21'h000000;
			ack_r        <= 1'b0;
			rdata_r      <= 32'h00000000;
			reload_r     <= 1'b1;
		end else begin
			ctrl_r       <= ctrl_nxt;
			ev_stat_r    <= ev_stat_nxt;
			ev_mask_r    <= ev_mask_nxt;
			fault_addr_r <= fault_addr_nxt;
			ack_r        <= ack_nxt;
			rdata_r      <= rdata_nxt;
			reload_r     <= reload_nxt;
		end
	end

	// Size survives ordinary reset; only power-up reloads it. The strap is
	// sampled one clock after power-up release, once synchronised.
	always_ff @(posedge mclk or posedge power_up_reset) begin
		if (power_up_reset) begin
			size_r     <= FLASH_SIZE;
			por_done_r <= 1'b0;
		end else begin
			por_done_r <= 1'b1;
			if (!por_done_r && force_q) begin
				size_r <= smh_pkg::RST_SIZE_FORCED;
			end else begin
				size_r <= size_nxt;
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;
endmodule

// [rtl/smh_pkg.sv]
// Purpose: shared constants and types for the host access control block
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes:   register words sit at word-aligned offsets from the block base
package smh_pkg;

	// Register byte offsets (printed 0xF900 is a multiple of 4, 0xF902 is not)
	localparam logic [23:0] IDX_CTRL_STATUS = 24'h00F900;
	localparam logic [23:0] IDX_TOP_SIZE    = 24'h00F902;
	localparam logic [7:0]  ADDR_CTRL_STATUS = 8'h00;
	localparam logic [7:0]  ADDR_TOP_SIZE    = 8'h08;
	localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h14;
	localparam logic [7:0]  ADDR_FAULT_INFO  = 8'h18;

	// Control/status field positions
	localparam int BIT_RD_FAULT  = 0;
	localparam int BIT_WR_FAULT  = 1;
	localparam int BIT_FAULT_IE  = 2;
	localparam int BIT_RESP_LO   = 3;
	localparam int BIT_PERMIT    = 5;
	localparam int BIT_SEM_FLAG  = 6;
	localparam int BIT_SEM_IE    = 7;

	// Reset values
	localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
	localparam logic [4:0] RST_SIZE_FIELD  = 5'h02;
	localparam logic [4:0] RST_SIZE_FORCED = 5'h00;
	localparam logic [2:0] RST_IRQ_MASK    = 3'h0;

	// Interrupt status bit positions
	localparam int EV_RD_FAULT = 0;
	localparam int EV_WR_FAULT = 1;
	localparam int EV_SEM      = 2;

	// Fault response modes
	typedef enum logic [1:0] {
		SMH_RESP_LONG_WAIT = 2'b00,
		SMH_RESP_READ_ZERO = 2'b01,
		SMH_RESP_ERR_SYNC  = 2'b10,
		SMH_RESP_RESERVED  = 2'b11
	} smh_resp_t;

	// Host access request from the bridge
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [20:0] addr;
		logic        blk_rd_prot;
		logic        blk_wr_prot;
		logic        sem_write;
	} smh_host_req_t;

	// Verdict returned to the bridge
	typedef struct packed {
		logic fault;
		logic long_wait;
		logic read_zero;
		logic err_sync;
		logic drop_write;
	} smh_host_rsp_t;

endpackage

// [tb/smh_checker.sv]
// Purpose: port assertions for the host access block
// Assumes: one mclk domain, async active-high reset
// Notes:   flags are internal, so checks tie outputs to requests
`timescale 1ns/1ps
module smh_checker #(
	parameter int AW = 21
) (
	input wire logic                   mclk,
	input wire logic                   reset,
	input wire logic                   wb_cyc_i,
	input wire logic                   wb_stb_i,
	input wire logic                   wb_ack_o,
	input wire smh_pkg::smh_host_req_t host_req,
	input wire smh_pkg::smh_host_rsp_t host_rsp,
	input wire logic                   bridge_write_permit,
	input wire logic [AW-1:0]          main_block_top_address
);
	logic rd_req;
	logic past_top;
	// Host access classes
	assign rd_req = host_req.valid && !host_req.write;
	assign past_top = host_req.addr >= main_block_top_address;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	a_ack_follows: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after request");
	a_rd_past_top: assert property (
		rd_req && past_top |-> host_rsp.fault)
		else $error("read past top passed");
	a_rd_allowed: assert property (
		rd_req && !past_top && !host_req.blk_rd_prot |-> !host_rsp.fault)
		else $error("allowed read faulted");
	a_wr_blocked: assert property (
		host_req.valid && host_req.write && (host_req.blk_rd_prot || past_top)
		|-> host_rsp.fault && host_rsp.drop_write)
		else $error("bad write passed");
	a_wait_reads: assert property (
		host_rsp.long_wait || host_rsp.read_zero |-> rd_req && host_rsp.fault)
		else $error("wait or zero off a faulting read");
	a_sync_only: assert property (
		host_rsp.err_sync |-> host_rsp.fault && !host_rsp.long_wait)
		else $error("error sync without fault");
	a_permit_ack: assert property (
		$changed(bridge_write_permit) |-> wb_ack_o)
		else $error("permit moved without write");
	a_top_units: assert property (
		main_block_top_address[15:0] == 16'h0000)
		else $error("top not in 64K units");
endmodule
bind smh_host_access_ctrl smh_checker #(.AW(AW)) u_smh_checker (
	.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .host_req,
	.host_rsp, .bridge_write_permit, .main_block_top_address);

// [tb/smh_host_access_ctrl_tb.sv]
// Purpose: self-checking bench for the host access block
// Assumes: Wishbone answer at any latency after the request
// Notes:   host side played by smh_host_model
`timescale 1ns/1ps
module smh_host_access_ctrl_tb;
	localparam logic [7:0]  CS = smh_pkg::ADDR_CTRL_STATUS;
	localparam logic [7:0]  SZ = smh_pkg::ADDR_TOP_SIZE;
	logic                   mclk, reset, power_up_reset, force_top_zero;
	logic                   development_environment, wb_cyc_i, wb_stb_i;
	logic                   wb_we_i, wb_ack_o, bridge_write_permit;
	logic                   core_override_reload, fault_irq, sem_irq, irq;
	logic [7:0]             wb_adr_i;
	logic [3:0]             wb_sel_i, host_semaphore_bits;
	logic [31:0]            wb_dat_i, wb_dat_o, q;
	logic [20:0]            main_block_top_address;
	smh_pkg::smh_host_req_t host_req;
	smh_pkg::smh_host_rsp_t host_rsp, r;
	int                     miscompares = 0, num_checks = 0, reloads = 0;
	smh_host_access_ctrl u_smh_host_access_ctrl (
		.mclk, .reset, .power_up_reset, .force_top_zero,
		.development_environment, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .host_req,
		.host_semaphore_bits, .host_rsp, .bridge_write_permit,
		.main_block_top_address, .core_override_reload, .fault_irq,
		.sem_irq, .irq);
	smh_host_model u_host (.mclk, .host_rsp, .host_req, .host_semaphore_bits);
	// 125 MHz clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Count reload pulses
	always @(posedge mclk)
		reloads += int'(core_override_reload === 1'b1);
	task automatic chk(input string n, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask
	// Classic cycle; waits for ack with no assumed latency
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
			{2'b11, w, a, 4'hF, d};
		do
			@(posedge mclk);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge mclk);
	endtask
	task automatic test_done();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic t_reset();
		wb(0, CS, 32'h0);
		chk("ctrl", q, 32'h0);
		wb(0, SZ, 32'h0);
		chk("size", q, 32'h2);
		chk("top", 32'(main_block_top_address), 32'h20000);
		wb(0, 8'hFC, 32'h0);
		chk("unmapped", q, 32'h0);
		wb(1, SZ, 32'h4);
		wb(0, SZ, 32'h0);
		chk("size ro", q, 32'h2);
		$display("reset test done");
	endtask
	task automatic t_size();
		int r0;
		development_environment <= 1'b1;
		repeat (3) @(posedge mclk);
		r0 = reloads;
		wb(1, SZ, 32'h4);
		wb(0, SZ, 32'h0);
		chk("size dev", q, 32'h4);
		chk("top", 32'(main_block_top_address), 32'h40000);
		chk("reload", 32'(reloads - r0), 32'h1);
		$display("size test done");
	endtask
	task automatic t_faults();
		for (int m = 0; m < 4; m++) begin
			wb(1, CS, (32'(m) << 3) | 32'h7);
			u_host.access(1'b0, 21'h04_0000, 1'b0, 1'b0, m, r);
			chk("rd rsp", 32'({r.fault, r.long_wait, r.read_zero, r.err_sync}),
				32'({1'b1, m == 0 || m == 3, m == 1, m == 2}));
			u_host.access(1'b1, 21'h00_0100, 1'b1, 1'b0, 0, r);
			chk("wr rsp", 32'({r.fault, r.err_sync, r.drop_write}),
				32'({1'b1, m == 2, 1'b1}));
			u_host.access(1'b0, 21'h03_FFFF, 1'b0, 1'b0, 0, r);
			chk("rd ok", 32'(r.fault), 32'h0);
			wb(1, CS, (32'(m) << 3) | 32'h4);
			wb(0, CS, 32'h0);
			chk("flags", q, (32'(m) << 3) | 32'h7);
			chk("fault irq", 32'(fault_irq), 32'h1);
			wb(0, smh_pkg::ADDR_FAULT_INFO, 32'h0);
			chk("fault addr", q, 32'h100);
			wb(1, CS, (32'(m) << 3) | 32'h7);
			chk("irq off", 32'(fault_irq), 32'h0);
		end
		$display("fault test done");
	endtask
	task automatic t_sem();
		wb(1, CS, 32'hA0);
		chk("permit", 32'(bridge_write_permit), 32'h1);
		wb(1, smh_pkg::ADDR_IRQ_MASK, 32'h4);
		u_host.access(1'b1, 21'h00_0003, 1'b0, 1'b1, 1, r);
		wb(1, CS, 32'hA0);
		wb(0, CS, 32'h0);
		chk("sem flag", q, 32'hE0);
		chk("irqs", 32'({sem_irq, irq}), 32'h3);
		wb(1, smh_pkg::ADDR_IRQ_STATUS, 32'h4);
		chk("irq", 32'(irq), 32'h0);
		wb(1, CS, 32'hC0);
		chk("sem irq", 32'(sem_irq), 32'h0);
		$display("semaphore test done");
	endtask
	task automatic t_force();
		force_top_zero <= 1'b1;
		{reset, power_up_reset} <= 2'b11;
		repeat (3) @(posedge mclk);
		{reset, power_up_reset} <= 2'b00;
		repeat (2) @(posedge mclk);
		wb(0, SZ, 32'h0);
		chk("size forced", q, 32'h0);
		chk("top", 32'(main_block_top_address), 32'h0);
		wb(0, CS, 32'h0);
		chk("ctrl", q, 32'h0);
		$display("force test done");
	endtask
	// Main sequence
	initial begin
		{reset, power_up_reset, force_top_zero, development_environment} = 4'hC;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		repeat (2) @(posedge mclk);
		{reset, power_up_reset} <= 2'b00;
		@(posedge mclk);
		t_reset();
		t_size();
		t_faults();
		t_sem();
		t_force();
		test_done();
	end
	// Watchdog
	initial begin
		#40000;
		miscompares++;
		test_done();
	end
endmodule

// [tb/smh_host_model.sv]
// Purpose: host side stand-in issuing shared memory accesses
// Assumes: one access per valid cycle, answer read mid-cycle
// Notes:   idle fields are inverted, sem_write cleared, so stale values never pass
`timescale 1ns/1ps
module smh_host_model (
	input  wire logic                   mclk,
	input  wire smh_pkg::smh_host_rsp_t host_rsp,
	output smh_pkg::smh_host_req_t      host_req,
	output logic [3:0]                  host_semaphore_bits
);
	// Idle at start
	initial begin
		host_req = '0;
		host_semaphore_bits = 4'hF;
	end
	// Gap makes the host prompt or slow
	task automatic access(input logic wr, input logic [20:0] a,
		input logic rp, input logic sem, input int gap,
		output smh_pkg::smh_host_rsp_t r);
		repeat (gap) @(posedge mclk);
		host_req <= '{1'b1, wr, a, rp, 1'b0, sem};
		host_semaphore_bits <= a[3:0];
		@(negedge mclk);
		r = host_rsp;
		@(posedge mclk);
		host_req <= '{1'b0, !wr, ~a, !rp, 1'b1, 1'b0};
		host_semaphore_bits <= ~a[3:0];
	endtask
endmodule
